// ==== hdl/frwp_pkg.sv ====
// constants for the flash region write protection block
package frwp_pkg;
    // register byte addresses on the AXI4-Lite slave
    localparam logic [7:0] ADDR_PROG_PROT0 = 8'h00;
    localparam logic [7:0] ADDR_PROG_PROT1 = 8'h04;
    localparam logic [7:0] ADDR_PROG_PROT2 = 8'h08;
    localparam logic [7:0] ADDR_PROG_PROT3 = 8'h0c;
    localparam logic [7:0] ADDR_DATA_PROT = 8'h10;
    localparam logic [7:0] ADDR_EEPROM_PROT = 8'h14;
    localparam logic [7:0] ADDR_SECURITY = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_GEOMETRY = 8'h20;
    // geometry
    localparam int PROG_REGIONS = 32;
    localparam int DATA_REGIONS = 8;
    localparam int EEPROM_REGIONS = 8;
    localparam int PROG_REG_BYTES = 4;
    // program array size code: 0 = 32 KB ... 5 = 1 MB, region = 1 KB << code
    localparam logic [2:0] PROG_SIZE_CODE_MAX = 3'h5;
    localparam int ADDR_W = 20;
    localparam int KB_SHIFT = 10;
    // mass erase enable field position and disabling value
    localparam int MASS_EN_LSB = 4;
    localparam logic [1:0] MASS_EN_OFF = 2'h2;
    // reset value of a protection byte: all unprotected
    localparam logic [7:0] PROT_OPEN = 8'hff;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // command codes from the flash command controller
    localparam logic [1:0] CMD_ERASE = 2'h0;
    localparam logic [1:0] CMD_PROGRAM = 2'h1;
    localparam logic [1:0] CMD_ERASE_ALL = 2'h2;
    // targets
    localparam logic [1:0] TGT_PROG = 2'h0;
    localparam logic [1:0] TGT_DATA = 2'h1;
    localparam logic [1:0] TGT_EEPROM = 2'h2;
    // status register bit positions
    localparam int ST_SPECIAL = 0;
    localparam int ST_MASS_DONE = 1;
    localparam int ST_ANY_PROT = 2;
    localparam int ST_CFG_LOCK = 3;
    // load sequence states, gray coded
    typedef enum logic [1:0] {
        FRWP_LOAD = 2'b00,
        FRWP_RUN = 2'b01
    } frwp_state_t;
endpackage

// ==== hdl/frwp_top.sv ====
// flash region write protection: registers, reset load and request checks
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// How it works
// [RULE_01] program array has 32 equal regions, four byte registers, one bit each
// [RULE_02] erase or program into a protected region is refused, firmware included
// [RULE_03] program region size is array size over 32, 1 KB to 32 KB
// [RULE_04] data flash is partitionable space minus eeprom backup portion
// [RULE_05] power of two data flash gives eight regions of size over 8
// [RULE_06] otherwise fixed region size, fewer regions, unused upper bits kept at 1; code does not force them to 1, it ignores them
// [RULE_07] eeprom store uses exactly 8 regions, total size over 8
// [RULE_08] every reset loads all protection registers from configuration bytes
// [RULE_09] debug or serial mass erase ignores protection if enabled, then clears
// [RULE_10] internal erase-all refused when any region of any type is protected
// [RULE_11] reprogramming configuration changes only reset defaults, not live registers
// [RULE_12] configuration rewrite only while its region is open; debugger only unsecured
// [RULE_13] outside special mode writes only add protection
// [RULE_14] special mode, only in serial port mode, allows removing protection
// [RULE_15] register writes are volatile; reset reloads configuration values
// [RULE_16] system should keep mass erase enabled when protecting and securing
// [RULE_17] mass erase enable field equal to 10 ignores mass erase requests
// [RULE_18] bit 1 unprotected, 0 protected; writes store old AND new
module frwp_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // configuration field bytes from the reset loader
    input wire logic [31:0] cfg_prog_prot,
    input wire logic [7:0] cfg_data_prot,
    input wire logic [7:0] cfg_eeprom_prot,
    input wire logic [7:0] cfg_security,
    // array geometry
    input wire logic [2:0] prog_size_code,
    input wire logic [3:0] data_regions_used,
    input wire logic [frwp_pkg::ADDR_W-1:0] data_region_kb,
    input wire logic [frwp_pkg::ADDR_W-1:0] eeprom_total_kb,
    // port modes
    input wire logic serial_port_mode,
    input wire logic device_secured,
    input wire logic special_mode_req,
    // request from the flash command controller
    input wire logic req_valid,
    input wire logic [1:0] req_cmd,
    input wire logic [1:0] req_target,
    input wire logic [19:0] req_addr,
    input wire logic req_from_debugger,
    // mass erase requests
    input wire logic mass_erase_dbg,
    input wire logic mass_erase_serial,
    // verdicts
    output logic req_grant,
    output logic req_refuse,
    output logic mass_erase_go,
    output logic cfg_locked
);
    ////////////////////////////////////////////////////////////////////////////
    frwp_pkg::frwp_state_t state_ff;
    logic [31:0] prog_ff;
    logic [7:0] data_ff, eeprom_ff, sec_ff;
    logic special_ff, mass_done_ff;
    logic aw_ff, w_ff, bv_ff, rv_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic grant_ff, refuse_ff, mass_ff, lock_ff;
    logic [2:0] sp_sync_ff, dbg_sync_ff, ser_sync_ff;

    // pin inputs pass two flops before use
    wire serial_mode_s = sp_sync_ff[1];
    wire mass_dbg_rise = dbg_sync_ff[1] & ~dbg_sync_ff[2];
    wire mass_ser_rise = ser_sync_ff[1] & ~ser_sync_ff[2];

    ////////////////////////////////////////////////////////////////////////////
    // region lookup
    wire [4:0] prog_shift = 5'(prog_size_code) + 5'(frwp_pkg::KB_SHIFT); // RULE_03
    wire [4:0] prog_idx = 5'(req_addr >> prog_shift); // RULE_01
    wire data_pow2 = (data_regions_used == 4'h8); // RULE_05
    // data flash size excludes eeprom backup; loader supplies the split
    wire [19:0] data_kb = 20'(req_addr >> frwp_pkg::KB_SHIFT); // RULE_04
    wire [19:0] data_div = (data_region_kb == '0) ? 20'h1 : data_region_kb;
    wire [19:0] data_q = data_kb / data_div; // RULE_06
    wire [2:0] data_idx = data_q[2:0];
    wire data_over = (data_q >= 20'(data_regions_used)) && !data_pow2;
    wire [19:0] eep_div = (eeprom_total_kb[19:3] == '0) ? 20'h1 : 20'(eeprom_total_kb >> 3);
    wire [19:0] eep_q = data_kb / eep_div; // RULE_07
    wire [2:0] eep_idx = eep_q[2:0];
    wire region_open =
        (req_target == frwp_pkg::TGT_PROG) ? prog_ff[prog_idx] :
        (req_target == frwp_pkg::TGT_DATA) ? (data_ff[data_idx] && !data_over) :
        (req_target == frwp_pkg::TGT_EEPROM) ? eeprom_ff[eep_idx] : 1'b0; // RULE_18
    // only used bits of the data register count; upper ones ignored
    wire [7:0] data_used_mask = data_pow2 ? 8'hff : 8'((9'h1 << data_regions_used) - 9'h1);
    wire any_prot = (prog_ff != 32'hffffffff) || ((~data_ff & data_used_mask) != 8'h00) ||
        (eeprom_ff != 8'hff); // RULE_10
    wire cfg_region_open = prog_ff[0]; // RULE_12
    wire mass_enabled = sec_ff[frwp_pkg::MASS_EN_LSB +: 2] != frwp_pkg::MASS_EN_OFF; // RULE_17
    wire mass_req = (mass_dbg_rise | (mass_ser_rise & serial_mode_s)) & mass_enabled; // RULE_09
    wire is_erase_all = req_cmd == frwp_pkg::CMD_ERASE_ALL;
    wire dbg_blocked = req_from_debugger & device_secured;
    wire req_ok = is_erase_all ? !any_prot : (region_open && !dbg_blocked); // RULE_02 RULE_10

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire do_write = aw_ff & w_ff & !bv_ff;
    wire [7:0] wbyte = wdata_ff[7:0];
    // special mode lets writes remove protection, otherwise old AND new
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
            input logic sp);
        merge = sp ? nw : (old & nw); // RULE_13 RULE_14 RULE_18
    endfunction
    wire wr_known = (awaddr_ff[7:2] <= frwp_pkg::ADDR_GEOMETRY[7:2]) && (awaddr_ff[1:0] == 2'h0);
    wire [31:0] status_word = {28'h0, lock_ff, any_prot, mass_done_ff, special_ff};
    logic [31:0] rd_mux;
    logic rd_known;
    always_comb begin
        rd_known = 1'b1;
        case (s_axi_araddr)
            frwp_pkg::ADDR_PROG_PROT0: rd_mux = {24'h0, prog_ff[7:0]};
            frwp_pkg::ADDR_PROG_PROT1: rd_mux = {24'h0, prog_ff[15:8]};
            frwp_pkg::ADDR_PROG_PROT2: rd_mux = {24'h0, prog_ff[23:16]};
            frwp_pkg::ADDR_PROG_PROT3: rd_mux = {24'h0, prog_ff[31:24]};
            frwp_pkg::ADDR_DATA_PROT: rd_mux = {24'h0, data_ff};
            frwp_pkg::ADDR_EEPROM_PROT: rd_mux = {24'h0, eeprom_ff};
            frwp_pkg::ADDR_SECURITY: rd_mux = {24'h0, sec_ff};
            frwp_pkg::ADDR_STATUS: rd_mux = status_word;
            frwp_pkg::ADDR_GEOMETRY: rd_mux = {25'h0, prog_size_code, data_regions_used};
            default: begin
                rd_mux = 32'h0;
                rd_known = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers and load sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp_sync_ff <= 3'h0;
            dbg_sync_ff <= 3'h0;
            ser_sync_ff <= 3'h0;
            state_ff <= frwp_pkg::FRWP_LOAD;
        end else begin
            sp_sync_ff <= {sp_sync_ff[1:0], serial_port_mode};
            dbg_sync_ff <= {dbg_sync_ff[1:0], mass_erase_dbg};
            ser_sync_ff <= {ser_sync_ff[1:0], mass_erase_serial};
            state_ff <= frwp_pkg::FRWP_RUN;
        end
    end

    // protection registers: open during reset, loaded on first edge after it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prog_ff <= {4{frwp_pkg::PROT_OPEN}};
            data_ff <= frwp_pkg::PROT_OPEN;
            eeprom_ff <= frwp_pkg::PROT_OPEN;
            sec_ff <= frwp_pkg::PROT_OPEN;
            mass_done_ff <= 1'b0;
        end else if (state_ff == frwp_pkg::FRWP_LOAD) begin
            prog_ff <= cfg_prog_prot; // RULE_08 RULE_15
            data_ff <= cfg_data_prot; // RULE_08
            eeprom_ff <= cfg_eeprom_prot; // RULE_08
            sec_ff <= cfg_security; // RULE_11
        end else if (mass_req) begin
            prog_ff <= {4{frwp_pkg::PROT_OPEN}}; // RULE_09
            data_ff <= frwp_pkg::PROT_OPEN;
            eeprom_ff <= frwp_pkg::PROT_OPEN;
            mass_done_ff <= 1'b1;
        end else if (do_write && wr_known) begin
            case (awaddr_ff)
                frwp_pkg::ADDR_PROG_PROT0: prog_ff[7:0] <= merge(prog_ff[7:0], wbyte, special_ff);
                frwp_pkg::ADDR_PROG_PROT1: prog_ff[15:8] <= merge(prog_ff[15:8], wbyte, special_ff);
                frwp_pkg::ADDR_PROG_PROT2:
                    prog_ff[23:16] <= merge(prog_ff[23:16], wbyte, special_ff);
                frwp_pkg::ADDR_PROG_PROT3:
                    prog_ff[31:24] <= merge(prog_ff[31:24], wbyte, special_ff);
                frwp_pkg::ADDR_DATA_PROT: data_ff <= merge(data_ff, wbyte, special_ff); // RULE_06
                frwp_pkg::ADDR_EEPROM_PROT: eeprom_ff <= merge(eeprom_ff, wbyte, special_ff);
                default: mass_done_ff <= mass_done_ff;
            endcase
        end
    end

    // special mode only while serial port mode holds
    always_ff @(posedge aclk) begin
        if (!aresetn)
            special_ff <= 1'b0;
        else
            special_ff <= special_mode_req & serial_mode_s; // RULE_14
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel: takes address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            bv_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0;
            bresp_ff <= frwp_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_ff) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_ff) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wstrb[0] ? s_axi_wdata : {24'h0, 8'hff};
            end
            if (do_write) begin
                bv_ff <= 1'b1;
                bresp_ff <= wr_known ? frwp_pkg::RESP_OKAY : frwp_pkg::RESP_SLVERR;
            end else if (bv_ff && s_axi_bready) begin
                bv_ff <= 1'b0;
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
            end
        end
    end

    // axi4-lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rv_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= frwp_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !rv_ff) begin
            rv_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_known ? frwp_pkg::RESP_OKAY : frwp_pkg::RESP_SLVERR;
        end else if (rv_ff && s_axi_rready) begin
            rv_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request verdicts, one cycle after the request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            grant_ff <= 1'b0;
            refuse_ff <= 1'b0;
            mass_ff <= 1'b0;
            lock_ff <= 1'b1;
        end else begin
            grant_ff <= req_valid && req_ok && state_ff == frwp_pkg::FRWP_RUN; // RULE_02
            refuse_ff <= req_valid && !(req_ok && state_ff == frwp_pkg::FRWP_RUN); // RULE_02
            mass_ff <= mass_req; // RULE_09 RULE_17
            lock_ff <= !cfg_region_open; // RULE_12
        end
    end

    assign s_axi_awready = !aw_ff;
    assign s_axi_wready = !w_ff;
    assign s_axi_bvalid = bv_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rv_ff;
    assign s_axi_rvalid = rv_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign req_grant = grant_ff;
    assign req_refuse = refuse_ff;
    assign mass_erase_go = mass_ff;
    assign cfg_locked = lock_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_refuse_protected: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid && !is_erase_all && !region_open |=> req_refuse && !req_grant) // RULE_02
        else $error("protected region request not refused");
    a_erase_all_block: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid && is_erase_all && any_prot |=> !req_grant) // RULE_10
        else $error("erase all granted with protection");
    a_add_only: assert property (@(posedge aclk) disable iff (!aresetn)
        !special_ff && state_ff == frwp_pkg::FRWP_RUN && !mass_req
        |=> (prog_ff & ~$past(prog_ff)) == 32'h0) // RULE_13
        else $error("protection removed outside special mode");
    a_load_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && state_ff == frwp_pkg::FRWP_LOAD |=> prog_ff == $past(cfg_prog_prot)) // RULE_08
        else $error("reset load missed");
    sequence s_mass_req;
        mass_req;
    endsequence
    a_mass_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        s_mass_req ##0 state_ff == frwp_pkg::FRWP_RUN |=> prog_ff == 32'hffffffff
        && mass_erase_go) // RULE_09
        else $error("mass erase did not clear");
    a_mass_en_block: assert property (@(posedge aclk) disable iff (!aresetn)
        sec_ff[frwp_pkg::MASS_EN_LSB +: 2] == frwp_pkg::MASS_EN_OFF |=> !mass_erase_go) // RULE_17
        else $error("mass erase with field disabled");
    a_special_only: assert property (@(posedge aclk) disable iff (!aresetn)
        special_ff |-> $past(serial_mode_s)) // RULE_14
        else $error("special mode without serial port");
    a_cfg_lock: assert property (@(posedge aclk) disable iff (!aresetn)
        !prog_ff[0] |=> cfg_locked) // RULE_12
        else $error("config region lock missing");
endmodule
`default_nettype wire

// ==== dv/frwp_cmd_model.sv ====
// request source standing in for the flash command controller
`timescale 1ns/1ps
`default_nettype none
module frwp_cmd_model (
    // clock
    input wire logic aclk,
    // request towards the protection block
    output logic req_valid,
    output logic [1:0] req_cmd,
    output logic [1:0] req_target,
    output logic [19:0] req_addr,
    output logic req_from_debugger
);
    initial begin
        req_valid = 1'b0;
        req_cmd = 2'h3;
        req_target = 2'h3;
        req_addr = 20'h0;
        req_from_debugger = 1'b0;
    end
    // one-cycle request; address and command inverted when idle so stale values never pass
    task automatic issue(input logic [1:0] c, input logic [1:0] t, input logic [19:0] a,
                         input logic d);
        @(posedge aclk);
        req_valid <= 1'b1;
        req_cmd <= c;
        req_target <= t;
        req_addr <= a;
        req_from_debugger <= d;
        @(posedge aclk);
        req_valid <= 1'b0;
        req_addr <= ~a;
        req_cmd <= ~c;
    endtask
endmodule
`default_nettype wire

// ==== dv/frwp_top_tb.sv ====
// self-checking bench for the flash region write protection block
`timescale 1ns/1ps
`default_nettype none
module frwp_top_tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, grant, refuse, go, locked;
    logic [7:0] awaddr, araddr, cfg_dp, cfg_ep, cfg_sec;
    logic [31:0] wdata, rdata, cfg_pp;
    logic [3:0] wstrb, dreg_used;
    logic [1:0] bresp, rresp, rq_cmd, rq_tgt;
    logic [2:0] size_code;
    logic [19:0] dreg_kb, ee_kb, rq_addr;
    logic serial, secured, special, me_dbg, me_ser, rq_valid, rq_dbg;
    logic [47:0] pm;
    logic exp_q[$];
    int seed = 96090;
    int num_errors = 0;
    int tests_run = 0;
    ////////////////////////////////////////////////////////////////////////////
    frwp_top frwp_top_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cfg_prog_prot(cfg_pp),
        .cfg_data_prot(cfg_dp), .cfg_eeprom_prot(cfg_ep), .cfg_security(cfg_sec),
        .prog_size_code(size_code), .data_regions_used(dreg_used),
        .data_region_kb(dreg_kb), .eeprom_total_kb(ee_kb), .serial_port_mode(serial),
        .device_secured(secured), .special_mode_req(special), .req_valid(rq_valid),
        .req_cmd(rq_cmd), .req_target(rq_tgt), .req_addr(rq_addr),
        .req_from_debugger(rq_dbg), .mass_erase_dbg(me_dbg), .mass_erase_serial(me_ser),
        .req_grant(grant), .req_refuse(refuse), .mass_erase_go(go), .cfg_locked(locked));
    frwp_cmd_model frwp_cmd_model_i (.aclk(aclk), .req_valid(rq_valid), .req_cmd(rq_cmd),
        .req_target(rq_tgt), .req_addr(rq_addr), .req_from_debugger(rq_dbg));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask
    // ready stays high: dropping it would clash with the next call in one step
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask
    // protection bytes sit in the low byte of words 0..5
    task automatic chk_all;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 6; i++) begin
            axr(8'(4 * i), d, r);
            chk({22'h0, r, d[7:0]}, {22'h0, frwp_pkg::RESP_OKAY, pm[8*i+:8]});
        end
    endtask
    task automatic wr_all(input logic [47:0] v, input logic spc);
        logic [1:0] r;
        for (int i = 0; i < 6; i++) begin
            axw(8'(4 * i), {24'h0, v[8*i+:8]}, r);
            chk({30'h0, r}, {30'h0, frwp_pkg::RESP_OKAY});
        end
        pm = spc ? v : (pm & v);
    endtask
    function automatic logic exp_of(input logic [1:0] c, input logic [1:0] t,
                                    input logic [19:0] a);
        if (c == frwp_pkg::CMD_ERASE_ALL) return &pm;
        if (t == frwp_pkg::TGT_PROG) return pm[a >> (10 + size_code)];
        if (t == frwp_pkg::TGT_DATA) return pm[32 + a / (dreg_kb * 1024)];
        return pm[40 + a / (ee_kb * 128)];
    endfunction
    task automatic req(input logic [1:0] c, input logic [1:0] t, input logic [19:0] a,
                       input logic d, input logic e);
        exp_q.push_back(e);
        frwp_cmd_model_i.issue(c, t, a, d);
    endtask
    task automatic count_go(output int n);
        n = 0;
        repeat (12) begin
            @(posedge aclk);
            if (go === 1'b1) n++;
        end
        me_dbg <= 1'b0;
        me_ser <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        if (grant === 1'b1 || refuse === 1'b1) begin
            if (exp_q.size() == 0) chk({30'h0, grant, refuse}, 32'h0);
            else chk({30'h0, grant, refuse}, {30'h0, exp_q[0], ~exp_q[0]});
            if (exp_q.size() != 0) exp_q.pop_front();
        end
    end
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        print_verdict;
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r, c, t;
        logic [19:0] a;
        int n;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {serial, secured, special, me_dbg, me_ser} = '0;
        {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
        cfg_pp = $random(seed);
        cfg_dp = 8'($random(seed));
        cfg_ep = 8'($random(seed));
        cfg_sec = 8'h20;
        {size_code, dreg_used, dreg_kb, ee_kb} = {3'h5, 4'h8, 20'h10, 20'h20};
        do_reset;
        pm = {cfg_ep, cfg_dp, cfg_pp};
        chk_all;
        axr(8'h40, d, r);
        chk({30'h0, r}, {30'h0, frwp_pkg::RESP_SLVERR});
        cfg_pp <= ~cfg_pp;
        cfg_dp <= ~cfg_dp;
        cfg_ep <= ~cfg_ep;
        special <= 1'b1;
        wr_all(48'({$random(seed), $random(seed)}), 1'b0);
        special <= 1'b0;
        chk_all;
        for (int k = 0; k < 18; k++) begin
            size_code <= 3'(k % 6);
            @(posedge aclk);
            t = 2'(k % 3);
            c = k[3] ? frwp_pkg::CMD_PROGRAM : frwp_pkg::CMD_ERASE;
            a = 20'($random(seed));
            if (t == 0) a = 20'(a & ((32'h8000 << size_code) - 1));
            else if (t == 1) a = 20'(a % (dreg_used * dreg_kb * 1024));
            else a = 20'(a % (ee_kb * 1024));
            req(c, t, a, 1'b0, exp_of(c, t, a));
        end
        req(frwp_pkg::CMD_ERASE_ALL, 2'h0, 20'h0, 1'b0, &pm);
        chk({31'h0, locked}, {31'h0, ~pm[0]});
        secured <= 1'b1;
        req(frwp_pkg::CMD_PROGRAM, frwp_pkg::TGT_PROG, 20'h0, 1'b1, 1'b0);
        secured <= 1'b0;
        req(frwp_pkg::CMD_PROGRAM, frwp_pkg::TGT_PROG, 20'h0, 1'b1, pm[0]);
        me_dbg <= 1'b1;
        count_go(n);
        chk(n, 0);
        chk_all;
        serial <= 1'b1;
        special <= 1'b1;
        repeat (4) @(posedge aclk);
        wr_all({8'hff, 8'hde, 32'hffff_fffe}, 1'b1);
        chk_all;
        chk({31'h0, locked}, 32'h1);
        {dreg_used, dreg_kb} <= {4'h6, 20'h20};
        @(posedge aclk);
        for (int j = 0; j < 6; j++) begin
            a = 20'(j * 32'h8000 + 32'h123);
            req(frwp_pkg::CMD_ERASE, frwp_pkg::TGT_DATA, a, 1'b0, exp_of(2'h0, 2'h1, a));
        end
        req(frwp_pkg::CMD_ERASE_ALL, 2'h0, 20'h0, 1'b0, 1'b0);
        serial <= 1'b0;
        special <= 1'b0;
        cfg_sec <= 8'h00;
        for (int s = 0; s < 2; s++) begin
            do_reset;
            pm = {cfg_ep, cfg_dp, cfg_pp};
            chk_all;
            me_dbg <= (s == 0);
            me_ser <= (s == 1);
            // serial mass erase only acts while serial port mode is up
            serial <= (s == 1);
            count_go(n);
            chk(n, 1);
            pm = '1;
            chk_all;
        end
        req(frwp_pkg::CMD_ERASE_ALL, 2'h0, 20'h0, 1'b0, 1'b1);
        repeat (4) @(posedge aclk);
        chk(exp_q.size(), 0);
        print_verdict;
    end
endmodule
`default_nettype wire
